//--- core/wdt_pkg.sv
// watchdog control package: register layout, reset values, timing counts
// assumes a 20 MHz core clock and a 32 kHz watchdog time base derived from it
// Summary of operation
// - prescale codes 0-7 select 16 ms..2048 ms
// - code 8 resets at once; above 8 reserved
// - for codes 0-7, interrupt-response bit gives interrupt, not reset
// - watchdog interrupt is high priority, unmaskable
// - timeout flag set on expiry; software clears
// - setting arm bit restarts the counter
// - software re-arms before period ends, else fires
// - arm cleared by software, reset, supply monitor
// - write takes effect only right after unlock
// - period is 2^prescale times 512 ticks
// - counter runs from a 32 kHz time base
package wdt_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR  = 8'hC0;
    localparam logic [7:0] CTRL_RESET = 8'h10;
    localparam int         PRE_LSB    = 4;
    localparam int         IRQM_BIT   = 3;
    localparam int         FLAG_BIT   = 2;
    localparam int         ARM_BIT    = 1;
    localparam int         UNLK_BIT   = 0;

    localparam logic [3:0] PRE_IMMEDIATE = 4'h8;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ     = 20_000_000;
    localparam int WD_HZ      = 32_000;
    localparam int TICK_DIV   = CLK_HZ / WD_HZ;
    localparam int BASE_TICKS = 512;
    localparam int CNT_W      = 17;

    typedef struct packed {
        logic [3:0] timeout_prescale;
        logic       irq_instead_of_reset;
        logic       timeout_flag;
        logic       dog_arm;
        logic       write_unlock;
    } ctrl_t;

endpackage : wdt_pkg

//--- core/wdt_tick.sv
// time-base divider: one-cycle enable pulse at the watchdog rate
// assumes the core clock is the only clock
`timescale 1ns/1ps
module wdt_tick #(
    parameter int DIV = wdt_pkg::TICK_DIV
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // enable out
    output logic      tick_q
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        tick_d;

    always_comb begin
        tick_d = (cnt_q == 16'(DIV - 1));
        cnt_d  = tick_d ? 16'h0000 : cnt_q + 16'h0001;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_q  <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end
endmodule : wdt_tick

//--- core/watchdog_timer_control.sv
// watchdog timer with a protected control register on the special-function bus
// assumes one core clock; sys_rst is the external hardware reset
`timescale 1ns/1ps
module watchdog_timer_control #(
    parameter int TICK_DIV = wdt_pkg::TICK_DIV
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // special-function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata_q,
    // instruction boundary and supply monitor
    input  wire logic       instr_end,
    input  wire logic       supply_monitor_irq,
    // watchdog actions
    output logic            wdt_reset_req_q,
    output logic            wdt_irq_q
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    wdt_pkg::ctrl_t                 ctrl_q;
    wdt_pkg::ctrl_t                 ctrl_d;
    logic [wdt_pkg::CNT_W-1:0]      cnt_q;
    logic [wdt_pkg::CNT_W-1:0]      cnt_d;
    logic                           restart_q;
    logic                           restart_d;
    logic                           tick;
    logic [7:0]                     rdata_d;
    logic                           rst_req_d;
    logic                           irq_d;
    logic                           ctrl_wr;
    logic                           wr_ok;
    logic                           immediate;
    logic                           expire;
    logic [wdt_pkg::CNT_W-1:0]      limit;
    logic [wdt_pkg::CNT_W-1:0]      cnt_next;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic logic is_ctrl_addr(input logic [7:0] addr);
        is_ctrl_addr = (addr == wdt_pkg::CTRL_ADDR);
    endfunction : is_ctrl_addr

    function automatic logic [wdt_pkg::CNT_W-1:0] period(input logic [3:0] pre);
        period = wdt_pkg::CNT_W'(wdt_pkg::BASE_TICKS) << pre[2:0];
    endfunction : period

    // ----------------------------------------------------------------
    // time base
    // ----------------------------------------------------------------
    wdt_tick #(
        .DIV     (TICK_DIV)
    ) u_tick (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .tick_q  (tick)
    );

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        ctrl_d    = ctrl_q;
        cnt_d     = cnt_q;
        restart_d = restart_q;
        rst_req_d = 1'b0;
        irq_d     = 1'b0;
        ctrl_wr   = sfr_wr && is_ctrl_addr(sfr_addr);
        cnt_next  = cnt_q + {{(wdt_pkg::CNT_W-1){1'b0}}, 1'b1};
        wr_ok     = ctrl_wr && ctrl_q.write_unlock;
        limit     = period(ctrl_q.timeout_prescale);
        // codes at or above 8 all fire at once
        immediate = ctrl_q.dog_arm && ctrl_q.timeout_prescale[3];
        expire    = 1'b0;

        // counter advances only on the time-base tick
        // disarmed: counter and any pending restart held clear
        if (!ctrl_q.dog_arm) begin
            cnt_d     = '0;
            restart_d = 1'b0;
        end else if (immediate) begin
            expire = 1'b1;
        end else if (tick) begin
            if (restart_q) begin
                cnt_d     = '0;
                restart_d = 1'b0;
            end else if (cnt_next >= limit) begin
                expire = 1'b1;
                cnt_d  = '0;
            end else begin
                cnt_d = cnt_next;
            end
        end

        // unlock handling
        // a locked write only loads the unlock bit, nothing else
        if (ctrl_wr && !ctrl_q.write_unlock) begin
            ctrl_d.write_unlock = sfr_wdata[wdt_pkg::UNLK_BIT];
        end else if (wr_ok || instr_end) begin
            ctrl_d.write_unlock = 1'b0;
        end

        if (wr_ok) begin
            ctrl_d.timeout_prescale     = sfr_wdata[wdt_pkg::PRE_LSB +: 4];
            ctrl_d.irq_instead_of_reset = sfr_wdata[wdt_pkg::IRQM_BIT];
            ctrl_d.dog_arm              = sfr_wdata[wdt_pkg::ARM_BIT];
            ctrl_d.timeout_flag         = ctrl_q.timeout_flag & sfr_wdata[wdt_pkg::FLAG_BIT];
            if (sfr_wdata[wdt_pkg::ARM_BIT]) begin
                restart_d = 1'b1;
            end
        end

        // expiry wins over a clearing write in the same cycle
        if (expire) begin
            ctrl_d.timeout_flag = 1'b1;
            if (ctrl_q.irq_instead_of_reset && !immediate) begin
                irq_d = 1'b1;
            end else begin
                rst_req_d      = 1'b1;
                ctrl_d.dog_arm = 1'b0;
            end
        end

        if (supply_monitor_irq) begin
            ctrl_d.dog_arm = 1'b0;
        end

        rdata_d = is_ctrl_addr(sfr_addr) ? ctrl_q : 8'h00;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_q          <= wdt_pkg::CTRL_RESET;
            cnt_q           <= '0;
            restart_q       <= 1'b0;
            sfr_rdata_q     <= 8'h00;
            wdt_reset_req_q <= 1'b0;
            wdt_irq_q       <= 1'b0;
        end else begin
            ctrl_q          <= ctrl_d;
            cnt_q           <= cnt_d;
            restart_q       <= restart_d;
            sfr_rdata_q     <= rdata_d;
            wdt_reset_req_q <= rst_req_d;
            wdt_irq_q       <= irq_d;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_unlocked_arm;
        ctrl_wr && ctrl_q.write_unlock && sfr_wdata[wdt_pkg::ARM_BIT] && !supply_monitor_irq;
    endsequence

    sequence s_locked_write;
        ctrl_wr && !ctrl_q.write_unlock;
    endsequence

    sequence s_disarmed;
        !ctrl_q.dog_arm;
    endsequence

    sequence s_clear_write;
        wr_ok && !sfr_wdata[wdt_pkg::FLAG_BIT] && !expire;
    endsequence

    sequence s_quiet_locked;
        ctrl_wr && !ctrl_q.write_unlock && !expire && !supply_monitor_irq;
    endsequence

    AST_IMMEDIATE: assert property (
        ctrl_q.dog_arm && ctrl_q.timeout_prescale == 4'h8 |=> wdt_reset_req_q)
        else $error("immediate code did not reset");
    AST_IRQ_NOT_RESET: assert property (
        wdt_irq_q |-> !wdt_reset_req_q && $past(ctrl_q.irq_instead_of_reset))
        else $error("interrupt response wrong");
    AST_FLAG_ON_EXPIRE: assert property (
        (wdt_irq_q || wdt_reset_req_q) |-> ctrl_q.timeout_flag)
        else $error("flag not set on timeout");
    AST_FLAG_STICKY: assert property (
        ctrl_q.timeout_flag && !wr_ok |=> ctrl_q.timeout_flag)
        else $error("flag cleared without a write");
    AST_LOCKED_WRITE: assert property (
        s_locked_write |=> $stable(ctrl_q.timeout_prescale))
        else $error("locked write changed prescale");
    AST_UNLOCK_DROP: assert property (
        ctrl_q.write_unlock && (instr_end || ctrl_wr) |=> !ctrl_q.write_unlock)
        else $error("unlock outlived one instruction");
    AST_PSM_DISARM: assert property (supply_monitor_irq |=> !ctrl_q.dog_arm)
        else $error("supply monitor did not disarm");
    AST_RESET_DISARM: assert property (wdt_reset_req_q |-> !ctrl_q.dog_arm)
        else $error("arm survived a watchdog reset");
    AST_RESTART: assert property (
        s_unlocked_arm |=> restart_q ##1 (restart_q || cnt_q == '0))
        else $error("arm write did not restart");
    AST_LIMIT: assert property (ctrl_q.dog_arm && !restart_q |-> cnt_q < limit)
        else $error("counter passed its period");
    AST_TICK_ONLY: assert property ($changed(cnt_q) && cnt_q != '0 |-> $past(tick))
        else $error("counter moved without a tick");

    AST_RESERVED_RESET: assert property (
        ctrl_q.dog_arm && ctrl_q.timeout_prescale[3] |=> wdt_reset_req_q && !wdt_irq_q)
        else $error("reserved code did not reset");
    AST_DISARMED_QUIET: assert property (
        s_disarmed |=> !wdt_reset_req_q && !wdt_irq_q)
        else $error("disarmed watchdog fired");
    AST_FLAG_CLEAR: assert property (
        s_clear_write |=> !ctrl_q.timeout_flag)
        else $error("flag survived a clearing write");
    AST_LOCKED_ARM: assert property (
        s_quiet_locked |=> $stable(ctrl_q.dog_arm))
        else $error("locked write changed arm");
    AST_UNLOCK_SOURCE: assert property (
        !ctrl_q.write_unlock && !ctrl_wr |=> !ctrl_q.write_unlock)
        else $error("unlock rose without a write");
    AST_RESET_ONE_SHOT: assert property (
        wdt_reset_req_q |=> !wdt_reset_req_q)
        else $error("reset request longer than one cycle");
    AST_EXPIRE_CLEARS: assert property (
        wdt_irq_q |-> cnt_q == '0)
        else $error("counter not restarted after interrupt");
endmodule : watchdog_timer_control

//--- verif/tb_watchdog_timer_control.sv
// self-checking bench for the watchdog control block
// assumes the design carries its own assertions; TICK_DIV is cut to 2
`timescale 1ns/1ps
module tb_watchdog_timer_control;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        sfr_wr = 1'b0;
    logic        instr_end = 1'b0;
    logic        supply_monitor_irq = 1'b0;
    logic [7:0]  sfr_addr = 8'h00;
    logic [7:0]  sfr_wdata = 8'h00;
    logic [7:0]  sfr_rdata_q;
    logic        wdt_reset_req_q;
    logic        wdt_irq_q;
    logic        rd_req = 1'b0;
    logic        rd_due = 1'b0;
    logic [7:0]  rq[$];
    logic [1:0]  pq[$];
    logic [31:0] seed = 32'h2cbb_1ac3;
    int          failures = 0;
    int          num_checks = 0;

    watchdog_timer_control #(.TICK_DIV(2)) u_watchdog_timer_control (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .instr_end(instr_end),
        .supply_monitor_irq(supply_monitor_irq), .wdt_reset_req_q(wdt_reset_req_q),
        .wdt_irq_q(wdt_irq_q));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic results();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk

    // ----------------------------------------------------------------
    // watcher: oldest note against each result
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (rd_due) begin
            chk("read data", rq.pop_front(), sfr_rdata_q);
        end
        if (wdt_reset_req_q === 1'b1 || wdt_irq_q === 1'b1) begin
            chk("action", {6'h00, (pq.size() != 0) ? pq.pop_front() : 2'b00},
                {6'h00, wdt_irq_q, wdt_reset_req_q});
        end
        rd_due <= rd_req;
    end

    // ----------------------------------------------------------------
    // driver, all at the falling edge
    // ----------------------------------------------------------------
    // one quiet edge, optionally with an instruction end or a supply alarm
    task automatic strobe(input logic ie, input logic supply_monitor);
        @(negedge ref_clk);
        sfr_wr = 1'b0;
        instr_end = ie;
        supply_monitor_irq = supply_monitor;
        rd_req = 1'b0;
    endtask : strobe

    task automatic idle(input int n);
        repeat (n) strobe(1'b0, 1'b0);
    endtask : idle

    task automatic wr(input logic [7:0] d);
        @(negedge ref_clk);
        sfr_addr = 8'hC0;
        sfr_wr = 1'b1;
        sfr_wdata = d;
        instr_end = 1'b0;
    endtask : wr

    task automatic prog(input logic [7:0] d);
        wr(8'h01);
        wr(d);
        idle(1);
    endtask : prog

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge ref_clk);
        sfr_addr = a;
        rd_req = 1'b1;
        rq.push_back(e);
        idle(2);
    endtask : rd

    task automatic waitq(input int n);
        for (int i = 0; i < n && pq.size() != 0; i++) idle(1);
        if (pq.size() != 0) begin
            failures++;
            $display("unexpected action: expected pulse seen none");
            results();
        end
    endtask : waitq

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        idle(16);
        sys_rst = 1'b0;
        rd(8'hC0, 8'h10);
        rd(8'h55, 8'h00);
        wr(8'(xs()) & 8'hFE);
        idle(1);
        rd(8'hC0, 8'h10);
        wr(8'h01);
        strobe(1'b1, 1'b0);
        wr(8'hFA);
        idle(1);
        rd(8'hC0, 8'h10);
        $display("test lock done");
        prog(8'h0A);
        rd(8'hC0, 8'h0A);
        idle(1012);
        pq.push_back(2'b10);
        waitq(16);
        rd(8'hC0, 8'h0E);
        prog(8'h08);
        rd(8'hC0, 8'h08);
        wr(8'h06);
        idle(1);
        rd(8'hC0, 8'h08);
        $display("test interrupt done");
        prog(8'h02);
        repeat (4) begin
            idle(600 + int'(xs() % 32'h0000_012c));
            prog(8'h02);
        end
        idle(1016);
        pq.push_back(2'b01);
        waitq(16);
        rd(8'hC0, 8'h04);
        prog(8'h12);
        idle(2036);
        pq.push_back(2'b01);
        waitq(30);
        rd(8'hC0, 8'h14);
        $display("test period done");
        for (int c = 8; c < 16; c++) begin
            pq.push_back(2'b01);
            prog({4'(c), c[0], 3'b010});
            waitq(8);
            rd(8'hC0, {4'(c), c[0], 3'b100});
        end
        $display("test immediate done");
        sys_rst = 1'b1;
        idle(2);
        sys_rst = 1'b0;
        rd(8'hC0, 8'h10);
        wr(8'h01);
        wr(8'h02);
        strobe(1'b0, 1'b1);
        idle(1);
        rd(8'hC0, 8'h00);
        idle(1100);
        $display("test supply done");
        results();
    end
endmodule : tb_watchdog_timer_control
